// ### logic/delivery_window.sv
// module: external delivery window after set-mask and clear-mask instructions
`timescale 1ns/1ps
module delivery_window import irq_pkg::*; #(
  parameter int BRIEF_CYCLES = 4,
  parameter int GUARD_CYCLES = 4
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // pipeline events
  input  wire logic ext_delivery_enable,
  input  wire logic set_mask_ext,
  input  wire logic clear_mask_ext,
  input  wire logic clear_pred,
  input  wire logic priv_zero,
  input  wire logic serialize,
  // result
  output logic      window_open
);

  typedef struct packed {
    logic       en_seen;
    logic       hold;
    logic [3:0] brief;
    logic [3:0] guard;
  } win_state_t;

  win_state_t s_r;
  win_state_t s_nxt;
  logic       unpriv_clear;
  logic       now_suppress;

  // clears inside a brief window are ignored too, so a steady stream cannot restart it
  assign unpriv_clear = clear_mask_ext && !priv_zero && (s_r.guard == 4'h0) && (s_r.brief == 4'h0);
  // any privileged clear-mask closes its own cycle, whatever the predicate
  assign now_suppress = (clear_mask_ext && priv_zero) || unpriv_clear; // [R16] [R17] [R18]

  always_comb begin
    s_nxt = s_r;
    // enable seen one cycle late, at once on serialize
    s_nxt.en_seen = ext_delivery_enable && !set_mask_ext; // [R14]
    if (clear_mask_ext && priv_zero && !clear_pred)
      s_nxt.hold = 1'b1;
    else if (serialize)
      s_nxt.hold = 1'b0; // [R19] [R20]
    if (unpriv_clear)
      s_nxt.brief = 4'(BRIEF_CYCLES);
    else if (s_r.brief != 4'h0)
      s_nxt.brief = s_r.brief - 4'h1;
    // after a brief window, unprivileged clears are ignored for a while
    if (s_r.brief == 4'h1)
      s_nxt.guard = 4'(GUARD_CYCLES); // [R21]
    else if (s_r.guard != 4'h0)
      s_nxt.guard = s_r.guard - 4'h1;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign window_open = ext_delivery_enable && (s_r.en_seen || serialize) && !s_r.hold
                       && (s_r.brief == 4'h0) && !now_suppress; // [R14] [R15]

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_true_pred;
    clear_mask_ext && priv_zero && clear_pred |-> !window_open;
  endproperty
  a_true_pred: assert property (p_true_pred) else $error("window open on true clear"); // [R18]

  property p_serial_ends;
    serialize && !clear_mask_ext |=> !s_r.hold;
  endproperty
  a_serial_ends: assert property (p_serial_ends) else $error("hold outlived serialize"); // [R19]

  property p_no_lockout;
    s_r.brief == 4'h1 |=> s_r.brief == 4'h0 && s_r.guard != 4'h0 ##1 !unpriv_clear;
  endproperty
  a_no_lockout: assert property (p_no_lockout) else $error("unprivileged lockout"); // [R21]

  c_false_pred: cover property (clear_mask_ext && priv_zero && !clear_pred ##[1:20] serialize);

endmodule

// ### logic/ext_vec_encoder.sv
// module: picks the highest ranked set bit of a 256-entry external vector map
`timescale 1ns/1ps
module ext_vec_encoder import irq_pkg::*; (
  // vector map
  input  wire logic [NUM_VEC-1:0] bits,
  // result
  output logic                    found,
  output logic [7:0]              vec
);

  always_comb begin
    found = 1'b0;
    vec   = VEC_SPURIOUS;
    // ascending scan, the last hit is the highest number
    for (int i = 16; i < NUM_VEC; i++) begin
      if (bits[i]) begin
        found = 1'b1;
        vec   = 8'(i);
      end
    end
    if (bits[VEC_LEGACY]) begin // [R5]
      found = 1'b1;
      vec   = VEC_LEGACY;
    end
    if (bits[VEC_NMI]) begin // [R5]
      found = 1'b1;
      vec   = VEC_NMI;
    end
  end

endmodule

// ### logic/interrupt_priority_mask_logic.sv
// module: local interrupt prioritizer with pending, in-service and task priority masking
`timescale 1ns/1ps
module interrupt_priority_mask_logic import irq_pkg::*; #(
  parameter int BRIEF_CYCLES = 4,
  parameter int GUARD_CYCLES = 4
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // pins from the board
  input  wire logic              init_pin,
  input  wire logic              pmi_pin,
  // interrupt messages, core clock
  input  wire logic              ext_msg_valid,
  input  wire logic [7:0]        ext_msg_vec,
  input  wire logic              pmi_msg_valid,
  input  wire logic [3:0]        pmi_msg_vec,
  // firmware completion
  input  wire logic              init_done,
  input  wire logic              pmi_done,
  input  wire logic [3:0]        pmi_done_vec,
  // processor status and pipeline
  input  wire logic              ext_delivery_enable,
  input  wire logic              collection_enable,
  input  wire logic              machine_check_mask,
  input  wire logic              legacy_mode,
  input  wire logic              legacy_override_flag,
  input  wire logic              legacy_interrupt_flag,
  input  wire logic              set_mask_ext,
  input  wire logic              clear_mask_ext,
  input  wire logic              clear_pred,
  input  wire logic              priv_zero,
  input  wire logic              serialize,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [DATA_W-1:0]      rdata,
  // accept indications
  output logic                   take_init,
  output logic                   take_pmi,
  output logic                   take_ext,
  output logic [3:0]             pmi_vec
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0]         init_sync;
    logic [1:0]         pmi_sync;
    logic               init_prev;
    logic               pmi_prev;
    logic               init_pending;
    logic [NUM_PMI-1:0] pmi_pending;
    logic [NUM_VEC-1:0] pending;
    logic [NUM_VEC-1:0] in_service;
    tpr_t               task_priority_reg;
    accept_t            acc;
    logic [DATA_W-1:0]  rdata;
  } core_state_t;

  core_state_t s_r;
  core_state_t s_nxt;

  logic        pend_found;
  logic [7:0]  pend_vec;
  logic        isv_found;
  logic [7:0]  isv_vec;
  logic        outranks;
  logic        unmasked;
  logic [7:0]  ack_vec;
  logic        ack_rd;
  logic        eos_wr;
  logic        win_open;
  logic        ext_enabled;
  logic        pmi_found;
  logic [3:0]  pmi_best;
  logic        init_edge;
  logic        pmi_edge;

  // ----------------------------------------
  // sub-blocks
  // ----------------------------------------
  ext_vec_encoder u_pend_enc (
    .bits  (s_r.pending),
    .found (pend_found),
    .vec   (pend_vec)
  );

  ext_vec_encoder u_isv_enc (
    .bits  (s_r.in_service),
    .found (isv_found),
    .vec   (isv_vec)
  );

  delivery_window #(
    .BRIEF_CYCLES (BRIEF_CYCLES),
    .GUARD_CYCLES (GUARD_CYCLES)
  ) u_window (
    .clock               (clock),
    .resetn              (resetn),
    .ext_delivery_enable (ext_delivery_enable),
    .set_mask_ext        (set_mask_ext),
    .clear_mask_ext      (clear_mask_ext),
    .clear_pred          (clear_pred),
    .priv_zero           (priv_zero),
    .serialize           (serialize),
    .window_open         (win_open)
  );

  // ----------------------------------------
  // masking and delivery
  // ----------------------------------------
  // only the single best pending vector is judged; a masked best gives spurious
  assign outranks = vec_rank(pend_found, pend_vec) > vec_rank(isv_found, isv_vec); // [R1] [R7] [R12]
  assign unmasked = pend_found && outranks
                    && ((pend_vec == VEC_NMI) // [R9] [R25]
                        || (!s_r.task_priority_reg.mmi && ((pend_vec == VEC_LEGACY) // [R9]
                                              || (pend_vec[7:4] > s_r.task_priority_reg.mic)))); // [R8]
  assign ack_vec  = unmasked ? pend_vec : VEC_SPURIOUS; // [R10]
  assign ack_rd   = rd && (addr == ADDR_VACK);
  assign eos_wr   = wr && (addr == ADDR_EOS);

  // legacy code execution adds the override term
  assign ext_enabled = win_open && (!legacy_mode || !legacy_override_flag || legacy_interrupt_flag); // [R6]

  assign init_edge = s_r.init_sync[1] && !s_r.init_prev;
  assign pmi_edge  = s_r.pmi_sync[1] && !s_r.pmi_prev;

  // platform-mgmt vectors ranked higher number first, like external vectors
  always_comb begin
    pmi_found = 1'b0;
    pmi_best  = 4'h0;
    for (int i = 0; i < NUM_PMI; i++) begin
      if (s_r.pmi_pending[i]) begin // [R1]
        pmi_found = 1'b1;
        pmi_best  = 4'(i);
      end
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    // pins cross into the core clock through two flops
    s_nxt.init_sync = {s_r.init_sync[0], init_pin};
    s_nxt.pmi_sync  = {s_r.pmi_sync[0], pmi_pin};
    s_nxt.init_prev = s_r.init_sync[1];
    s_nxt.pmi_prev  = s_r.pmi_sync[1];

    // clears first, so a same-cycle arrival wins
    if (init_done)
      s_nxt.init_pending = 1'b0;
    if (init_edge)
      s_nxt.init_pending = 1'b1;
    if (pmi_done)
      s_nxt.pmi_pending[pmi_done_vec] = 1'b0;
    // separate space from external vectors
    if (pmi_msg_valid)
      s_nxt.pmi_pending[pmi_msg_vec] = 1'b1; // [R2] [R23]
    if (pmi_edge)
      s_nxt.pmi_pending[PMI_PIN_VEC] = 1'b1; // [R3]

    if (ack_rd && unmasked) begin
      s_nxt.pending[pend_vec]    = 1'b0; // [R24]
      s_nxt.in_service[pend_vec] = 1'b1; // [R12]
    end
    if (eos_wr && isv_found)
      s_nxt.in_service[isv_vec] = 1'b0; // [R13]
    // reserved and spurious numbers are dropped
    if (ext_msg_valid && vec_valid(ext_msg_vec))
      s_nxt.pending[ext_msg_vec] = 1'b1; // [R4] [R23]

    if (wr && (addr == ADDR_TPR)) begin
      s_nxt.task_priority_reg.mic = wdata[MIC_LSB +: 4];
      s_nxt.task_priority_reg.mmi = wdata[MMI_BIT];
    end

    // one accept at a time; a source not taken simply stays pending
    s_nxt.acc.take_init = s_r.init_pending && !machine_check_mask; // [R22] [R11]
    s_nxt.acc.take_pmi  = pmi_found && collection_enable && !s_nxt.acc.take_init; // [R22] [R1]
    s_nxt.acc.take_ext  = ext_enabled && unmasked
                          && !s_nxt.acc.take_init && !s_nxt.acc.take_pmi; // [R11] [R1]
    s_nxt.acc.pmi_vec   = pmi_best;

    // read data stands for one cycle only
    s_nxt.rdata = '0;
    if (rd) begin
      if (addr == ADDR_TPR)
        s_nxt.rdata = DATA_W'({s_r.task_priority_reg.mmi, 12'h000, s_r.task_priority_reg.mic, 4'h0});
      else if (addr == ADDR_VACK)
        s_nxt.rdata = DATA_W'(ack_vec); // [R24] [R10]
      else if (addr == ADDR_STATUS)
        s_nxt.rdata = {isv_found, 7'h00, isv_vec, s_r.pmi_pending[14:0], s_r.init_pending};
      else if (addr[3] == ADDR_PRB[3])
        s_nxt.rdata = s_r.pending[32 * addr[2:0] +: 32];
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r     <= '0; // [R26]
      s_r.task_priority_reg <= '{mic: MIC_RST, mmi: MMI_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata     = s_r.rdata;
  assign take_init = s_r.acc.take_init;
  assign take_pmi  = s_r.acc.take_pmi;
  assign take_ext  = s_r.acc.take_ext;
  assign pmi_vec   = s_r.acc.pmi_vec;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_spurious;
    ack_rd && !unmasked |=> rdata == 32'h0000000F;
  endproperty
  a_spurious: assert property (p_spurious) else $error("masked read not spurious"); // [R10]

  property p_ack_clears;
    ack_rd && unmasked && !(ext_msg_valid && ext_msg_vec == pend_vec)
      |=> !s_r.pending[$past(pend_vec)] && rdata == 32'($past(pend_vec));
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("acknowledge left pending"); // [R24]

  property p_ack_service;
    ack_rd && unmasked |=> s_r.in_service[$past(pend_vec)] ##0 isv_found;
  endproperty
  a_ack_service: assert property (p_ack_service) else $error("vector not in service"); // [R12]

  property p_eos;
    eos_wr && isv_found |=> !s_r.in_service[$past(isv_vec)];
  endproperty
  a_eos: assert property (p_eos) else $error("end of service ignored"); // [R13]

  property p_mmi;
    s_r.task_priority_reg.mmi && pend_found && pend_vec != VEC_NMI |-> !unmasked;
  endproperty
  a_mmi: assert property (p_mmi) else $error("mask all leaked"); // [R25]

  property p_mic;
    pend_found && pend_vec >= VEC_FIRST && pend_vec[7:4] <= s_r.task_priority_reg.mic |-> !unmasked;
  endproperty
  a_mic: assert property (p_mic) else $error("class mask leaked"); // [R8]

  property p_order;
    take_init |-> !take_pmi && !take_ext;
  endproperty
  a_order: assert property (p_order) else $error("init not exclusive"); // [R1]

  property p_pin;
    pmi_edge |=> s_r.pmi_pending[PMI_PIN_VEC];
  endproperty
  a_pin: assert property (p_pin) else $error("pin not pended"); // [R3]

  property p_reserved;
    !s_r.pending[1] && s_r.pending[15:3] == 13'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved vector pended"); // [R4]

  property p_legacy;
    legacy_mode && legacy_override_flag && !legacy_interrupt_flag |=> !take_ext;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy gate ignored"); // [R6]

  property p_collect;
    !collection_enable |=> !take_pmi;
  endproperty
  a_collect: assert property (p_collect) else $error("pmi taken without collection"); // [R22]

  c_ack:    cover property (ack_rd && unmasked);
  c_nested: cover property (ack_rd && unmasked && isv_found);
  c_ext:    cover property (take_ext);
  c_init:   cover property (take_init ##[1:10] take_pmi);

endmodule

// ### logic/irq_pkg.sv
// package: constants, state types and ranking helpers for the interrupt prioritizer
// Summary of operation
// [R1] init above platform-mgmt above external; vector ranking
// [R2] platform-mgmt vectors separate; 0-3 platform, 4+ firmware
// [R3] platform-mgmt pin pends platform-mgmt vector 0
// [R4] 8-bit external vectors; 1 and 3-14 reserved
// [R5] vector 2 above vector 0 above 16-255
// [R6] delivery enable, legacy mode adds override term
// [R7] 15 classes; among 16-255 higher vector number always wins
// [R8] 16-255 unmasked: mmi clear, outranks service, class>mic
// [R9] vector 0 needs mmi clear; vector 2 only outranking
// [R10] nothing deliverable reads back spurious vector 15
// [R11] pending held until enabled and unmasked, then taken
// [R12] acknowledge read marks vector in service, raises masking
// [R13] end-of-service clears highest in-service vector
// [R14] set-mask honoured by next serialization at latest
// [R15] serialize opens window one cycle before clear
// [R16] clear-mask effective from the next instruction
// [R17] privileged clear-mask may suppress whole group
// [R18] privileged true-predicate clear-mask disables right after
// [R19] false-predicate suppression ends at next serialization
// [R20] suppression never exceeds those limits
// [R21] unprivileged clear-mask suppression brief, no lockout
// [R22] init needs machine-check mask 0; pmi collection 1
// [R23] one pending bit per vector; repeats merge
// [R24] acknowledge returns best unmasked vector, clears pending
// [R25] mask_all_maskable masks everything except vector 2
// [R26] reset clears pending and in-service bits
package irq_pkg;

  // ----------------------------------------
  // register port map
  // ----------------------------------------
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 32;
  localparam logic [3:0]  ADDR_TPR     = 4'h0;
  localparam logic [3:0]  ADDR_VACK    = 4'h1;
  localparam logic [3:0]  ADDR_EOS     = 4'h2;
  localparam logic [3:0]  ADDR_STATUS  = 4'h3;
  localparam logic [3:0]  ADDR_PRB     = 4'h8;
  localparam int          MIC_LSB      = 4;
  localparam int          MMI_BIT      = 16;

  // ----------------------------------------
  // vectors and reset values
  // ----------------------------------------
  localparam int          NUM_VEC      = 256;
  localparam int          NUM_PMI      = 16;
  localparam logic [7:0]  VEC_LEGACY   = 8'h00;
  localparam logic [7:0]  VEC_NMI      = 8'h02;
  localparam logic [7:0]  VEC_SPURIOUS = 8'h0F;
  localparam logic [7:0]  VEC_FIRST    = 8'h10;
  localparam logic [3:0]  PMI_PIN_VEC  = 4'h0;
  localparam logic [3:0]  MIC_RST      = 4'h0;
  localparam logic        MMI_RST      = 1'b0;

  typedef struct packed {
    logic [3:0] mic;
    logic       mmi;
  } tpr_t;

  typedef struct packed {
    logic       take_init;
    logic       take_pmi;
    logic       take_ext;
    logic [3:0] pmi_vec;
  } accept_t;

  // only deliverable vectors may be pended
  function automatic logic vec_valid(input logic [7:0] v);
    return (v == VEC_LEGACY) || (v == VEC_NMI) || (v >= VEC_FIRST);
  endfunction

  // 0 means none; vector 2 above vector 0 above 16..255 by number
  function automatic logic [8:0] vec_rank(input logic found, input logic [7:0] v);
    if (!found)
      return 9'h000;
    else if (v == VEC_NMI)
      return 9'h101;
    else if (v == VEC_LEGACY)
      return 9'h100;
    else
      return {1'b0, v};
  endfunction

endpackage

// ### testbench/irq_partner.sv
// partner: interrupt message source and pipeline event driver
`timescale 1ns/1ps
module irq_partner (
  // clock
  input  wire logic clock,
  // messages and pins
  output logic      ext_msg_valid,
  output logic[7:0] ext_msg_vec,
  output logic      pmi_msg_valid,
  output logic[3:0] pmi_msg_vec,
  output logic      init_pin,
  output logic      pmi_pin,
  // pipeline events
  output logic      set_mask_ext,
  output logic      clear_mask_ext,
  output logic      clear_pred,
  output logic      serialize
);
  initial begin
    {ext_msg_valid, pmi_msg_valid, init_pin, pmi_pin} = 4'h0;
    {set_mask_ext, clear_mask_ext, clear_pred, serialize} = 4'h0;
    ext_msg_vec = 8'h00;
    pmi_msg_vec = 4'h0;
  end
  // idle bus shows the inverse, so a stale vector never looks fresh
  task automatic send_ext(input logic [7:0] v);
    @(posedge clock);
    ext_msg_valid <= 1'b1;
    ext_msg_vec   <= v;
    @(posedge clock);
    ext_msg_valid <= 1'b0;
    ext_msg_vec   <= ~v;
  endtask
  task automatic send_pmi(input logic [3:0] v);
    @(posedge clock);
    pmi_msg_valid <= 1'b1;
    pmi_msg_vec   <= v;
    @(posedge clock);
    pmi_msg_valid <= 1'b0;
    pmi_msg_vec   <= ~v;
  endtask
  // pins held long enough for the synchronizer
  task automatic pulse_pin(input logic is_init);
    @(posedge clock);
    init_pin <= is_init;
    pmi_pin  <= !is_init;
    repeat (4) @(posedge clock);
    init_pin <= 1'b0;
    pmi_pin  <= 1'b0;
  endtask
  // 0 set-mask, 1 serialize, 2 clear-mask
  task automatic event_pulse(input int which, input logic pred);
    @(posedge clock);
    set_mask_ext   <= (which == 0);
    serialize      <= (which == 1);
    clear_mask_ext <= (which >= 2);
    clear_pred     <= pred;
    @(posedge clock);
    set_mask_ext   <= 1'b0;
    serialize      <= 1'b0;
    clear_mask_ext <= 1'b0;
  endtask
  // serialize, two idle cycles, then the clear-mask closes the window
  task automatic sample_seq();
    event_pulse(1, 1'b0);
    @(posedge clock);
    event_pulse(2, 1'b1);
  endtask
endmodule

// ### testbench/tb_top.sv
// testbench: random and directed checks of the interrupt prioritizer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import irq_pkg::*;
  logic        clock, resetn, init_done, pmi_done, wr, rd;
  logic        ext_delivery_enable, collection_enable, machine_check_mask, priv_zero;
  logic        legacy_mode, legacy_override_flag, legacy_interrupt_flag;
  logic        ext_msg_valid, pmi_msg_valid, init_pin, pmi_pin;
  logic        set_mask_ext, clear_mask_ext, clear_pred, serialize;
  logic        take_init, take_pmi, take_ext;
  logic [7:0]  ext_msg_vec;
  logic [3:0]  pmi_msg_vec, pmi_done_vec, pmi_vec, addr;
  logic [31:0] wdata, rdata;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          seen_ext = 0;
  integer      seed = 32'h0ec0a741;

  irq_partner p (.clock(clock), .ext_msg_valid(ext_msg_valid), .ext_msg_vec(ext_msg_vec),
    .pmi_msg_valid(pmi_msg_valid), .pmi_msg_vec(pmi_msg_vec), .init_pin(init_pin), .pmi_pin(pmi_pin),
    .set_mask_ext(set_mask_ext), .clear_mask_ext(clear_mask_ext), .clear_pred(clear_pred),
    .serialize(serialize));
  interrupt_priority_mask_logic #(.BRIEF_CYCLES(2), .GUARD_CYCLES(2)) dut (.clock(clock), .resetn(resetn),
    .init_pin(init_pin), .pmi_pin(pmi_pin), .ext_msg_valid(ext_msg_valid), .ext_msg_vec(ext_msg_vec),
    .pmi_msg_valid(pmi_msg_valid), .pmi_msg_vec(pmi_msg_vec), .init_done(init_done), .pmi_done(pmi_done),
    .pmi_done_vec(pmi_done_vec), .ext_delivery_enable(ext_delivery_enable),
    .collection_enable(collection_enable), .machine_check_mask(machine_check_mask),
    .legacy_mode(legacy_mode), .legacy_override_flag(legacy_override_flag),
    .legacy_interrupt_flag(legacy_interrupt_flag), .set_mask_ext(set_mask_ext),
    .clear_mask_ext(clear_mask_ext), .clear_pred(clear_pred), .priv_zero(priv_zero),
    .serialize(serialize), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .take_init(take_init), .take_pmi(take_pmi), .take_ext(take_ext), .pmi_vec(pmi_vec));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (take_ext === 1'b1) seen_ext <= seen_ext + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic ack(input logic [7:0] e);
    logic [31:0] d;
    reg_rd(ADDR_VACK, d);
    `CHK("ack", {24'h000000, e}, d)
  endtask
  // data of the end-of-service write is don't-care, so send all ones
  task automatic eos();
    reg_wr(ADDR_EOS, 32'hFFFFFFFF);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic done(input string s);
    $display("test %s done, errors %0d", s, num_errors);
  endtask
  function automatic logic [7:0] fix(input logic [7:0] v);
    return (v < 8'h10 && v != 8'h00 && v != 8'h02) ? (v | 8'h10) : v;
  endfunction
  function automatic logic [8:0] rank(input logic [7:0] v);
    return (v == 8'h02) ? 9'h101 : (v == 8'h00) ? 9'h100 : {1'b0, v};
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0]  a, b;
    logic [31:0] d;
    int          n0;
    {resetn, wr, rd, init_done, pmi_done, priv_zero} = 6'h01;
    {ext_delivery_enable, collection_enable, machine_check_mask} = 3'h1;
    {legacy_mode, legacy_override_flag, legacy_interrupt_flag} = 3'h0;
    addr = 4'h0;
    wdata = 32'h00000000;
    pmi_done_vec = 4'h0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    ack(8'h0F);
    done("reset");
    for (int i = 0; i < 4; i++) p.send_ext(i == 0 ? 8'h20 : i == 1 ? 8'h40 : i == 2 ? 8'h02 : 8'h00);
    ack(8'h02);
    ack(8'h0F);
    eos(); ack(8'h00); eos();
    ack(8'h40); eos(); ack(8'h20); eos(); ack(8'h0F);
    done("ranking");
    p.send_ext(8'h30); ack(8'h30); p.send_ext(8'h20); ack(8'h0F);
    p.send_ext(8'h50); ack(8'h50); reg_rd(ADDR_STATUS, d);
    `CHK("status", 32'h80500000, d)
    eos(); ack(8'h0F);
    eos(); ack(8'h20); eos();
    done("nesting");
    reg_wr(ADDR_TPR, 32'h00000040);
    reg_rd(ADDR_TPR, d);
    `CHK("tpr", 32'h00000040, d)
    p.send_ext(8'h4F); ack(8'h0F); p.send_ext(8'h50); ack(8'h50); eos();
    reg_wr(ADDR_TPR, 32'h00000000); ack(8'h4F); eos();
    reg_wr(ADDR_TPR, 32'h00010000);
    p.send_ext(8'h00); p.send_ext(8'h80); p.send_ext(8'h02);
    ack(8'h02); eos(); ack(8'h0F);
    reg_wr(ADDR_TPR, 32'h00000000); ack(8'h00); eos(); ack(8'h80); eos();
    done("task priority");
    for (int i = 0; i < 4; i++) p.send_ext(i == 0 ? 8'h01 : i == 1 ? 8'h03 : i == 2 ? 8'h0E : 8'h0F);
    ack(8'h0F);
    reg_rd(ADDR_PRB, d);
    `CHK("prb0", 32'h00000000, d)
    p.send_ext(8'h40); p.send_ext(8'h40);
    reg_rd(ADDR_PRB + 4'h2, d);
    `CHK("prb2", 32'h00000001, d)
    ack(8'h40);
    reg_rd(ADDR_PRB + 4'h2, d);
    `CHK("prb2", 32'h00000000, d)
    eos(); ack(8'h0F);
    done("pending bits");
    for (int i = 0; i < 12; i++) begin
      // status flags and idle completions wander; acknowledge ignores them
      {init_done, pmi_done, priv_zero, legacy_mode, legacy_override_flag, legacy_interrupt_flag} <= 6'($random(seed));
      {ext_delivery_enable, collection_enable, machine_check_mask, pmi_done_vec} <= 7'($random(seed));
      a = fix(8'($random(seed)));
      b = fix(8'($random(seed)));
      p.send_ext(a);
      p.send_ext(b);
      ack(rank(a) >= rank(b) ? a : b);
      eos();
      ack(a == b ? 8'h0F : rank(a) >= rank(b) ? b : a);
      eos();
    end
    {init_done, pmi_done, legacy_mode, legacy_override_flag, legacy_interrupt_flag} <= 5'h00;
    {priv_zero, collection_enable, machine_check_mask} <= 3'h5;
    done("random pairs");
    p.send_ext(8'h90);
    ext_delivery_enable <= 1'b1;
    p.event_pulse(0, 1'b0); settle(3);
    `CHK("take_ext", 1'b1, take_ext)
    legacy_mode <= 1'b1; legacy_override_flag <= 1'b1; settle(3);
    `CHK("take_ext", 1'b0, take_ext)
    legacy_interrupt_flag <= 1'b1; settle(3);
    `CHK("take_ext", 1'b1, take_ext)
    legacy_mode <= 1'b0;
    p.event_pulse(2, 1'b1); ext_delivery_enable <= 1'b0; settle(2);
    `CHK("take_ext", 1'b0, take_ext)
    ext_delivery_enable <= 1'b1; p.event_pulse(2, 1'b0); settle(4);
    `CHK("take_ext", 1'b0, take_ext)
    p.event_pulse(1, 1'b0); settle(3);
    `CHK("take_ext", 1'b1, take_ext)
    priv_zero <= 1'b0;
    repeat (3) p.event_pulse(2, 1'b0);
    settle(8);
    `CHK("take_ext", 1'b1, take_ext)
    ext_delivery_enable <= 1'b0; settle(3);
    n0 = seen_ext;
    ext_delivery_enable <= 1'b1; p.sample_seq(); ext_delivery_enable <= 1'b0; settle(2);
    `CHK("window", 1'b1, seen_ext > n0)
    ack(8'h90); eos();
    done("delivery window");
    collection_enable <= 1'b1; machine_check_mask <= 1'b0;
    p.pulse_pin(1'b0); settle(6);
    `CHK("take_pmi", 1'b1, take_pmi)
    `CHK("pmi_vec", 4'h0, pmi_vec)
    p.send_pmi(4'h3); settle(3);
    `CHK("pmi_vec", 4'h3, pmi_vec)
    p.pulse_pin(1'b1); settle(6);
    `CHK("take_init", 1'b1, take_init)
    `CHK("take_pmi", 1'b0, take_pmi)
    machine_check_mask <= 1'b1; settle(3);
    `CHK("take_init", 1'b0, take_init)
    `CHK("take_pmi", 1'b1, take_pmi)
    collection_enable <= 1'b0; settle(3);
    `CHK("take_pmi", 1'b0, take_pmi)
    init_done <= 1'b1; pmi_done <= 1'b1; pmi_done_vec <= 4'h3; settle(1);
    pmi_done_vec <= 4'h0; settle(1);
    init_done <= 1'b0; pmi_done <= 1'b0; collection_enable <= 1'b1; machine_check_mask <= 1'b0; settle(3);
    `CHK("take_init", 1'b0, take_init)
    `CHK("take_pmi", 1'b0, take_pmi)
    done("firmware sources");
    end_sim();
  end
endmodule
